// ---- src/btb_regs.vh ----
// Encodings, field positions, widths and phase codes for the decode/execute slice
`ifndef BTB_REGS_VH
`define BTB_REGS_VH

`define BTB_OP_INVERT_HI 4'h7
`define BTB_OP_BRANCH_HI 4'he
`define BTB_OP_BOV_LO 4'h4
`define BTB_OP_BZ_LO 4'h0
`define BTB_F_TOP_MSB 15
`define BTB_F_TOP_LSB 12
`define BTB_F_SUB_MSB 11
`define BTB_F_SUB_LSB 8
`define BTB_F_BIT_MSB 11
`define BTB_F_BIT_LSB 9
`define BTB_F_BANKSEL 8
`define BTB_F_ADDR_MSB 7
`define BTB_F_ADDR_LSB 0
`define BTB_ACCESS_BANK 4'h0
`define BTB_PC_STEP 21'h000002
`define BTB_Q1 2'h0
`define BTB_Q2 2'h1
`define BTB_Q3 2'h2
`define BTB_Q4 2'h3
`define BTB_RST_PC 21'h000000

`endif

// ---- src/btb_decode.v ----
// Instruction word decoder for the bit invert and conditional branch forms
`timescale 1ns/1ps
`include "btb_regs.vh"

module btb_decode (
  // Instruction word
  input wire [15:0] instr_i,
  // Decoded operation
  output wire is_invert_o,
  output wire is_bov_o,
  output wire is_bz_o,
  output wire [2:0] bit_idx_o,
  output wire bank_sel_o,
  output wire [7:0] reg_addr_o,
  output wire [7:0] offset_o
);

  assign is_invert_o = instr_i[`BTB_F_TOP_MSB:`BTB_F_TOP_LSB] == `BTB_OP_INVERT_HI;
  assign is_bov_o = (instr_i[`BTB_F_TOP_MSB:`BTB_F_TOP_LSB] == `BTB_OP_BRANCH_HI) &&
                    (instr_i[`BTB_F_SUB_MSB:`BTB_F_SUB_LSB] == `BTB_OP_BOV_LO);
  assign is_bz_o = (instr_i[`BTB_F_TOP_MSB:`BTB_F_TOP_LSB] == `BTB_OP_BRANCH_HI) &&
                   (instr_i[`BTB_F_SUB_MSB:`BTB_F_SUB_LSB] == `BTB_OP_BZ_LO);
  assign bit_idx_o = instr_i[`BTB_F_BIT_MSB:`BTB_F_BIT_LSB];
  assign bank_sel_o = instr_i[`BTB_F_BANKSEL];
  assign reg_addr_o = instr_i[`BTB_F_ADDR_MSB:`BTB_F_ADDR_LSB];
  assign offset_o = instr_i[`BTB_F_ADDR_MSB:`BTB_F_ADDR_LSB];

endmodule

// ---- src/btb_exec.v ----
// Four-phase execute unit: bit invert read-modify-write and conditional branches
`timescale 1ns/1ps
`include "btb_regs.vh"

// Functional notes
// - Invert only the indexed bit of register
// - Bank bit zero selects access bank
// - Invert: one word, one cycle, flags untouched
// - Overflow branch taken only when overflow set
// - Zero branch taken only when zero set
// - Offset is signed, doubled to bytes
// - Taken: PC+2+2n, two cycles; else one
module btb_exec #(
  parameter PC_W = 21
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // Fetched instruction, valid at start of each cycle
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  // Status flags and bank select
  input wire flag_ovf_i,
  input wire flag_zero_i,
  input wire [3:0] bank_select_register_i,
  // Data memory
  input wire [7:0] dmem_rdata_i,
  output reg [11:0] dmem_addr_o,
  output reg dmem_rd_o,
  output reg dmem_wr_o,
  output reg [7:0] dmem_wdata_o,
  // Program counter
  output reg [PC_W-1:0] pc_o,
  output reg pc_load_o,
  // Phase and cycle state
  output wire [1:0] phase_o,
  output wire flush_o,
  output wire fetch_o
);

  reg [1:0] q_ff;
  reg flush_ff;
  reg [15:0] ir_ff;
  reg [7:0] data_ff;
  reg [PC_W-1:0] pc_ff;
  reg taken_ff;
  reg [PC_W-1:0] nxt_pc;

  wire is_invert;
  wire is_bov;
  wire is_bz;
  wire [2:0] bit_idx;
  wire bank_sel;
  wire [7:0] reg_addr;
  wire [7:0] offset;

  btb_decode u_dec (
    .instr_i(ir_ff),
    .is_invert_o(is_invert),
    .is_bov_o(is_bov),
    .is_bz_o(is_bz),
    .bit_idx_o(bit_idx),
    .bank_sel_o(bank_sel),
    .reg_addr_o(reg_addr),
    .offset_o(offset)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [PC_W-1:0] branch_target;
    input [PC_W-1:0] pc_now;
    input [7:0] n;
    reg [PC_W-1:0] disp;
    begin
      disp = {{(PC_W-9){n[7]}}, n, 1'b0};
      branch_target = pc_now + `BTB_PC_STEP + disp;
    end
  endfunction

  function [7:0] flip_bit;
    input [7:0] val;
    input [2:0] idx;
    begin
      flip_bit = val ^ (8'h01 << idx);
    end
  endfunction

  wire take_bov = is_bov & flag_ovf_i;
  wire take_bz = is_bz & flag_zero_i;
  wire live = ~flush_ff;
  wire taken = live & (take_bov | take_bz);

  assign phase_o = q_ff;
  assign flush_o = flush_ff;
  assign fetch_o = (q_ff == `BTB_Q4);

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Free running: one instruction every four clocks
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      q_ff <= `BTB_Q1;
    end else begin
      q_ff <= q_ff + 2'h1;
    end
  end

  // ----------------------------------------
  // Branch decision
  // ----------------------------------------
  // Flags are valid in Q3 only; keep the verdict for the Q4 edge
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      taken_ff <= 1'b0;
    end else if (q_ff == `BTB_Q3) begin
      taken_ff <= taken;
    end
  end

  // ----------------------------------------
  // Instruction latch
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      ir_ff <= 16'h0000;
      flush_ff <= 1'b0;
    end else if (q_ff == `BTB_Q4) begin
      // Missing word runs as a no-op
      ir_ff <= instr_valid_i ? instr_i : 16'h0000;
      flush_ff <= taken_ff;
    end
  end

  // ----------------------------------------
  // Program counter tracking
  // ----------------------------------------
  // target, step or hold
  always @* begin
    nxt_pc = pc_ff + `BTB_PC_STEP;
    if (taken_ff) begin
      nxt_pc = branch_target(pc_ff, offset);
    end else if (flush_ff) begin
      // Discarded word consumes no address
      nxt_pc = pc_ff;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pc_ff <= `BTB_RST_PC;
    end else if (q_ff == `BTB_Q4) begin
      pc_ff <= nxt_pc;
    end
  end

  // ----------------------------------------
  // Data memory read-modify-write
  // ----------------------------------------
  // Read in Q2, write back in Q4
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      dmem_addr_o <= 12'h000;
      dmem_rd_o <= 1'b0;
      dmem_wr_o <= 1'b0;
      dmem_wdata_o <= 8'h00;
      data_ff <= 8'h00;
    end else begin
      dmem_rd_o <= 1'b0;
      dmem_wr_o <= 1'b0;
      case (q_ff)
        `BTB_Q1: begin
          if (live & is_invert) begin
            dmem_addr_o <= {bank_sel ? bank_select_register_i : `BTB_ACCESS_BANK, reg_addr};
            dmem_rd_o <= 1'b1;
          end
        end
        `BTB_Q2: begin
          if (live & is_invert) begin
            // Read data valid at end of Q2
            data_ff <= dmem_rdata_i;
          end
        end
        `BTB_Q3: begin
          if (live & is_invert) begin
            dmem_wdata_o <= flip_bit(data_ff, bit_idx);
            // write in same cycle, no flags
            dmem_wr_o <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program counter load
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pc_o <= `BTB_RST_PC;
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      // Flags sampled here, at the end of Q3
      if ((q_ff == `BTB_Q3) && taken) begin
        pc_o <= branch_target(pc_ff, offset);
        pc_load_o <= 1'b1;
      end
    end
  end

endmodule

// ---- tb/btb_exec_chk.sv ----
// Port checker for the execute unit
`timescale 1ns/1ps
module btb_exec_chk (
  input wire sys_clk_i,
  input wire reset_i,
  input wire [11:0] dmem_addr_o,
  input wire dmem_rd_o,
  input wire dmem_wr_o,
  input wire pc_load_o,
  input wire [1:0] phase_o,
  input wire flush_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_rd_in_q2: assert property (dmem_rd_o |-> phase_o == 2'h1)
    else $error("rd phase");
  a_rd_then_wr: assert property (dmem_rd_o |-> ##2 dmem_wr_o)
    else $error("no wr");
  a_wr_in_q4: assert property (dmem_wr_o |-> phase_o == 2'h3 && $past(dmem_rd_o, 2))
    else $error("wr alone");
  a_addr_held: assert property (dmem_rd_o |=> $stable(dmem_addr_o) [*2])
    else $error("addr moved");
  a_load_in_q4: assert property (pc_load_o |-> phase_o == 2'h3 && !dmem_wr_o)
    else $error("load phase");
  a_flush_after: assert property (pc_load_o |=> flush_o [*4])
    else $error("no flush");
  a_flush_quiet: assert property (flush_o |-> !(dmem_rd_o || dmem_wr_o || pc_load_o))
    else $error("flush busy");
  a_phase_step: assert property (!reset_i |=> phase_o == $past(phase_o) + 2'h1)
    else $error("phase skip");
  c_wr: cover property (dmem_wr_o);
  c_ld: cover property (pc_load_o);
  c_fl: cover property (flush_o ##1 !flush_o);
endmodule
bind btb_exec btb_exec_chk btb_exec_chk_i (.*);

// ---- tb/bit_toggle_branch_exec_tb.sv ----
// Random and corner bench for the execute unit
`timescale 1ns/1ps
`define CHK(n,e,s) begin n_checks++; if ((e) !== (s)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module bit_toggle_branch_exec_tb;
  reg sys_clk_i = 0, reset_i = 1, instr_valid_i = 0, flag_ovf_i = 0, flag_zero_i = 0;
  reg [15:0] instr_i = 0;
  reg [3:0] bank_select_register_i = 0;
  reg [7:0] dmem_rdata_i = 0;
  wire dmem_rd_o, dmem_wr_o, pc_load_o, flush_o, fetch_o;
  wire [11:0] dmem_addr_o;
  wire [7:0] dmem_wdata_o;
  wire [20:0] pc_o;
  wire [1:0] phase_o;
  int error_cnt = 0, n_checks = 0, k;
  reg [20:0] mpc = 21'h000002, xpc = 0;
  reg pw = 0, pl = 0, pf = 0;
  reg [7:0] xwd = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  btb_exec btb_exec_i (.*);
  task test_done;
    $display("checks %0d bad %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Samples Q4 of the previous word, then Q1..Q3 of this one
  task run(input [15:0] w, input v, input z);
    int nr;
    reg [11:0] a;
    reg tk;
    nr = 0;
    a = 0;
    @(posedge sys_clk_i);
    instr_i <= w;
    instr_valid_i <= 1;
    flag_ovf_i <= v;
    flag_zero_i <= z;
    bank_select_register_i <= $urandom;
    dmem_rdata_i <= $urandom;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) @(posedge sys_clk_i);
      #1;
      `CHK("fetch", i == 0, fetch_o)
      if (i == 0) begin
        `CHK("wr", pw, dmem_wr_o)
        `CHK("ld", pl, pc_load_o)
        if (pw) `CHK("wdata", xwd, dmem_wdata_o)
        if (pl) `CHK("pc", xpc, pc_o)
      end else begin
        `CHK("flush", pf, flush_o)
        if (dmem_rd_o) begin
          nr++;
          a = dmem_addr_o;
        end
      end
    end
    tk = !pf && w[15:12] == 4'he && (w[11:8] == 4'h4 && v || w[11:8] == 4'h0 && z);
    pw = !pf && w[15:12] == 4'h7;
    `CHK("reads", int'(pw), nr)
    if (pw) `CHK("addr", {w[8] ? bank_select_register_i : 4'h0, w[7:0]}, a)
    xwd = dmem_rdata_i ^ (8'h01 << w[11:9]);
    xpc = mpc + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0};
    pl = tk;
    if (!pf) mpc = tk ? xpc : mpc + 21'h000002;
    pf = tk;
    $display("word %h done", w);
  endtask
  initial begin
    k = $urandom(32'h4a125240);
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 0;
    for (k = 0; k < 9 && phase_o !== 2'h2; k++) @(negedge sys_clk_i);
    if (k == 9) error_cnt++;
    else begin
      run(16'he47f, 1, 0);
      run(16'h7100, 1, 1);
      run(16'he080, 0, 1);
      run(16'he405, 0, 1);
      run(16'he005, 1, 0);
      run(16'h7e00, 1, 1);
      repeat (60) begin
        k = $urandom % 3;
        run({k ? 4'he : 4'h7, k == 1 ? 4'h4 : k == 2 ? 4'h0 : 4'($urandom), 8'($urandom)},
          1'($urandom), 1'($urandom));
      end
      run(16'h0000, 0, 0);
    end
    test_done();
  end
endmodule
